// ==== design/asf_framer.sv ====
// Serial lane framer: pads samples, splits octets, inserts K28.5 on sync
//
// Function
// - Each 14-bit sample is widened to 16 bits with zeros below its LSB.
// - Octet one is the eight upper bits, octet two the six low bits then two zeros.
// - Single-lane mode sends both octets on lane 0, dual-lane one on each lane.
// - Single-lane mode is in force after reset until dual-lane is selected.
// - While sync is requested, sample data is replaced by K28.5 code groups.
// - K28.5 reaches the lanes nine clocks after the falling sync edge is latched.
// - The sync pin is sampled on mclk through three synchroniser stages and taken once two agree.
// - Valid data resumes about 50 us after complete or fast power-down ends.
// - Valid data resumes about 10 us after software power-down ends.
// - Valid data resumes about 5 us after the sample clock restarts.
// - Normal data returns eight clocks after the sync request is released.
`timescale 1ns/1ns
`include "asf_cfg.svh"
module asf_framer
   import asf_pkg::*;
(
   // Clock and reset
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   // Sample source
   input  wire logic [`ASF_SAMPLE_BITS-1:0] sample_in,
   input  wire logic                        sample_valid,
   output logic                             sample_ready,
   // Pins
   input  wire logic                        sync_n,
   input  wire logic                        dual_lane,
   input  wire logic                        pd_full,
   input  wire logic                        pd_fast,
   input  wire logic                        pd_soft,
   // Clock monitor
   input  wire logic                        clk_restart,
   // Lanes
   output logic [9:0]                       lane0_code,
   output logic [9:0]                       lane1_code,
   output logic [1:0]                       lane_valid,
   output logic                             lane_k,
   input  wire logic                        lane_ready
);

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   logic [`ASF_PIN_W-1:0]        pin_s1;
   logic [`ASF_PIN_W-1:0]        pin_s2;
   logic [`ASF_PIN_W-1:0]        pin_s3;
   logic [`ASF_PIN_W-1:0]        pin_act;
   logic                         sync_req;
   logic                         dual_act;
   logic                         pd_any;
   logic [`ASF_SYNC_ON_LAT-2:0]  hist;
   logic                         k_sel;
   logic                         pd_prev;
   logic                         pd_long;
   logic [`ASF_WAKE_W-1:0]       wake_cnt;
   asf_state_type                st;
   asf_state_type                next_st;
   logic [`ASF_SAMPLE_BITS-1:0]  mem [`ASF_BUF_DEPTH];
   logic                         wr_ptr;
   logic                         rd_ptr;
   logic [1:0]                   cnt;
   logic [1:0]                   next_cnt;
   logic                         push;
   logic                         pop;
   logic                         adv;
   logic                         halt;
   logic [1:0]                   next_lv;
   asf_sym_type                  next_sym0;
   asf_sym_type                  next_sym1;
   asf_octets_type               head;

   function automatic asf_octets_type build_octets(input logic [`ASF_SAMPLE_BITS-1:0] s);
      logic [`ASF_WORD_BITS-1:0] word;
      asf_octets_type            oct;
      word   = {s, {`ASF_PAD_BITS{1'b0}}};
      oct.hi = word[15:8];
      oct.lo = word[7:0];
      return oct;
   endfunction

   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   // A pin change counts only once stages two and three agree
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1  <= `ASF_PIN_RESET;
         pin_s2  <= `ASF_PIN_RESET;
         pin_s3  <= `ASF_PIN_RESET;
         pin_act <= `ASF_PIN_RESET;
      end else begin
         pin_s1  <= {sync_n, dual_lane, pd_full, pd_fast, pd_soft};
         pin_s2  <= pin_s1;
         pin_s3  <= pin_s2;
         pin_act <= (pin_act & (pin_s2 ^ pin_s3)) | (pin_s2 & ~(pin_s2 ^ pin_s3));
      end
   end

   assign sync_req = ~pin_act[`ASF_PIN_SYNC_N];
   assign dual_act = pin_act[`ASF_PIN_DUAL];
   assign pd_any   = pin_act[`ASF_PIN_PD_FULL] | pin_act[`ASF_PIN_PD_FAST] |
                     pin_act[`ASF_PIN_PD_SOFT];

   // -------------------------------------------------------------------------
   // Sync latency line
   // -------------------------------------------------------------------------
   // Asymmetric taps give nine clocks to enter and eight to leave
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hist <= '0;
      end else begin
         hist <= {hist[`ASF_SYNC_ON_LAT-3:0], sync_req};
      end
   end

   assign k_sel = hist[`ASF_SYNC_ON_LAT-2] & hist[`ASF_SYNC_OFF_LAT-2];

   // -------------------------------------------------------------------------
   // Wake-up timing
   // -------------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pd_prev  <= 1'b0;
         pd_long  <= 1'b0;
         wake_cnt <= '0;
      end else begin
         pd_prev <= pd_any;
         if (pd_any) begin
            pd_long  <= pin_act[`ASF_PIN_PD_FULL] | pin_act[`ASF_PIN_PD_FAST];
            wake_cnt <= '0;
         end else if (pd_prev) begin
            wake_cnt <= pd_long ? `ASF_WAKE_W'(`ASF_WAKE_FULL_CYC)
                                : `ASF_WAKE_W'(`ASF_WAKE_SOFT_CYC);
         end else if (clk_restart) begin
            wake_cnt <= `ASF_WAKE_W'(`ASF_WAKE_CLK_CYC);
         end else if (wake_cnt != '0) begin
            wake_cnt <= wake_cnt - `ASF_WAKE_W'(1);
         end
      end
   end

   assign halt = pd_any | pd_prev | clk_restart | (wake_cnt != '0);

   // -------------------------------------------------------------------------
   // Two-entry sample buffer
   // -------------------------------------------------------------------------
   assign push     = sample_valid & sample_ready;
   assign next_cnt = cnt + {1'b0, push} - {1'b0, pop & adv};
   assign head     = build_octets(mem[rd_ptr]);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr       <= 1'b0;
         rd_ptr       <= 1'b0;
         cnt          <= 2'h0;
         sample_ready <= 1'b1;
      end else begin
         wr_ptr       <= wr_ptr ^ push;
         rd_ptr       <= rd_ptr ^ (pop & adv);
         cnt          <= next_cnt;
         sample_ready <= (next_cnt != 2'h2);
      end
   end

   // Data storage carries no reset
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr] <= sample_in;
      end
   end

   // -------------------------------------------------------------------------
   // Symbol selection
   // -------------------------------------------------------------------------
   // A held word on the lanes blocks the next one and is dropped only by a power-down or clock-restart halt
   assign adv = (st != ST_WAKE) && !halt && !((|lane_valid) && !lane_ready);

   always_comb begin
      next_sym0 = '{k: 1'b1, octet: `ASF_K28_5_OCTET};
      next_sym1 = '{k: 1'b1, octet: `ASF_K28_5_OCTET};
      next_lv   = 2'b00;
      pop       = 1'b0;
      next_st   = ST_RUN;
      if (k_sel) begin
         // Sample data is discarded while the receiver realigns
         next_lv = dual_act ? 2'b11 : 2'b01;
         pop     = (cnt != 2'h0);
      end else if (st == ST_OCT2) begin
         next_sym0 = '{k: 1'b0, octet: head.lo};
         next_lv   = 2'b01;
         pop       = 1'b1;
      end else if (cnt != 2'h0) begin
         next_sym0 = '{k: 1'b0, octet: head.hi};
         next_sym1 = '{k: 1'b0, octet: head.lo};
         if (dual_act) begin
            next_lv = 2'b11;
            pop     = 1'b1;
         end else begin
            next_lv = 2'b01;
            next_st = ST_OCT2;
         end
      end
   end

   // -------------------------------------------------------------------------
   // State and lane flags
   // -------------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_RUN;
      end else if (halt) begin
         st <= ST_WAKE;
      end else begin
         case (st)
            ST_WAKE: begin
               st <= ST_RUN;
            end
            ST_RUN, ST_OCT2: begin
               if (adv) begin
                  st <= next_st;
               end
            end
            default: begin
               st <= ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lane_valid <= 2'b00;
         lane_k     <= 1'b0;
      end else if (halt) begin
         lane_valid <= 2'b00;
         lane_k     <= 1'b0;
      end else if (adv) begin
         lane_valid <= next_lv;
         lane_k     <= k_sel;
      end else if (lane_ready) begin
         lane_valid <= 2'b00;
      end
   end

   // -------------------------------------------------------------------------
   // Lane encoders
   // -------------------------------------------------------------------------
   asf_lane_enc u_enc0 (
      .mclk (mclk),
      .rst_n(rst_n),
      .load (adv & next_lv[0]),
      .sym  (next_sym0),
      .code (lane0_code)
   );

   asf_lane_enc u_enc1 (
      .mclk (mclk),
      .rst_n(rst_n),
      .load (adv & next_lv[1]),
      .sym  (next_sym1),
      .code (lane1_code)
   );

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   octet_pack_a: assert property (@(posedge mclk) disable iff (!rst_n)
      adv && !k_sel && st == ST_RUN && cnt != 2'h0 |->
         next_sym0.octet == {mem[rd_ptr][13:6]} &&
         next_sym1.octet == {mem[rd_ptr][5:0], 2'b00})
      else $error("sample octets packed wrongly");

   single_split_a: assert property (@(posedge mclk) disable iff (!rst_n)
      adv && !k_sel && !dual_act && st == ST_RUN && cnt != 2'h0 && !halt
         |=> st == ST_OCT2 && lane_valid == 2'b01)
      else $error("single lane did not split sample");

   lane1_use_a: assert property (@(posedge mclk) disable iff (!rst_n)
      lane_valid[1] |-> $past(dual_act))
      else $error("second lane used in single-lane mode");

   k_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ($rose(sync_req) && !halt && lane_ready && st != ST_WAKE) ##1
         (sync_req && !halt && lane_ready && st != ST_WAKE)[*8] |=> lane_k && lane_valid[0])
      else $error("K28.5 not on lane nine clocks after sync");

   k_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ($fell(sync_req) && k_sel && !halt && lane_ready) ##1
         (!sync_req && !halt && lane_ready)[*7] |=> !lane_k)
      else $error("data not back eight clocks after sync release");

   k_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
      lane_k && lane_valid[0] |->
         lane0_code == `ASF_K28_5_NEG || lane0_code == `ASF_K28_5_POS)
      else $error("sync period carries non K28.5 code");

   sync_capture_a: assert property (@(posedge mclk) disable iff (!rst_n)
      pin_s2[`ASF_PIN_SYNC_N] == pin_s3[`ASF_PIN_SYNC_N] |=>
         pin_act[`ASF_PIN_SYNC_N] == $past(pin_s2[`ASF_PIN_SYNC_N]))
      else $error("sync pin level not taken when stable");

   wake_long_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(pd_any) && pd_long |=> wake_cnt == 10'd1000)
      else $error("long power-down wake count wrong");

   wake_soft_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(pd_any) && !pd_long |=> wake_cnt == 10'd200)
      else $error("software power-down wake count wrong");

   wake_clk_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !pd_any && !pd_prev && clk_restart |=> wake_cnt == 10'd100 ##1 lane_valid == 2'b00)
      else $error("clock restart wake count wrong");

endmodule // asf_framer

// ==== design/asf_cfg.svh ====
// Constants of the serial lane framer: timing counts, pin fields, code values
`ifndef ASF_CFG_SVH
`define ASF_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and widths
// ----------------------------------------------------------------------------
`define ASF_CLK_PERIOD_NS 50
`define ASF_SAMPLE_BITS   14
`define ASF_WORD_BITS     16
`define ASF_PAD_BITS      2
`define ASF_BUF_DEPTH     2

// ----------------------------------------------------------------------------
// Sync request latencies in sample clocks
// ----------------------------------------------------------------------------
`define ASF_SYNC_ON_LAT   9
`define ASF_SYNC_OFF_LAT  8
`define ASF_T_CLK_INT_PS  10500

// ----------------------------------------------------------------------------
// Wake-up times and derived counts (longest times, rounded down)
// ----------------------------------------------------------------------------
`define ASF_T_WAKE_FULL_US 50
`define ASF_T_WAKE_SOFT_US 10
`define ASF_T_WAKE_CLK_US  5
`define ASF_WAKE_W         10
`define ASF_WAKE_FULL_CYC  ((`ASF_T_WAKE_FULL_US * 1000) / `ASF_CLK_PERIOD_NS)
`define ASF_WAKE_SOFT_CYC  ((`ASF_T_WAKE_SOFT_US * 1000) / `ASF_CLK_PERIOD_NS)
`define ASF_WAKE_CLK_CYC   ((`ASF_T_WAKE_CLK_US * 1000) / `ASF_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Pin vector fields and reset value
// ----------------------------------------------------------------------------
`define ASF_PIN_W       5
`define ASF_PIN_SYNC_N  4
`define ASF_PIN_DUAL    3
`define ASF_PIN_PD_FULL 2
`define ASF_PIN_PD_FAST 1
`define ASF_PIN_PD_SOFT 0
`define ASF_PIN_RESET   5'h10

// ----------------------------------------------------------------------------
// Code groups
// ----------------------------------------------------------------------------
`define ASF_K28_5_OCTET 8'hBC
`define ASF_K28_5_NEG   10'h0FA
`define ASF_K28_5_POS   10'h305

`endif

// ==== design/asf_pkg.sv ====
// Types shared by the serial lane framer modules
package asf_pkg;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_WAKE = 2'b00,
      ST_RUN  = 2'b01,
      ST_OCT2 = 2'b10
   } asf_state_type;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } asf_octets_type;

   typedef struct packed {
      logic       k;
      logic [7:0] octet;
   } asf_sym_type;

endpackage

// ==== design/asf_lane_enc.sv ====
// One lane's 8b10b encoder with running disparity and a registered code
`timescale 1ns/1ns
`include "asf_cfg.svh"
module asf_lane_enc
   import asf_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Symbol in
   input  wire logic        load,
   input  wire asf_sym_type sym,
   // Code out, bit 9 sent first
   output logic [9:0]       code
);

   // -------------------------------------------------------------------------
   // Tables for negative running disparity
   // -------------------------------------------------------------------------
   localparam logic [5:0] TAB6 [32] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] TAB4 [8] = '{
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

   logic       rd;
   logic [9:0] next_code;
   logic       next_rd;
   logic [4:0] x;
   logic [2:0] y;
   logic [5:0] c6;
   logic [3:0] c4;
   logic       rd6;
   logic       alt7;

   // -------------------------------------------------------------------------
   // Encoding
   // -------------------------------------------------------------------------
   always_comb begin
      x    = sym.octet[4:0];
      y    = sym.octet[7:5];
      c6   = TAB6[x];
      rd6  = ($countones(c6) == 3) ? rd : ~rd;
      if (rd && (($countones(c6) != 3) || (x == 5'h07))) begin
         c6 = ~c6;
      end
      // Alternate x.7 avoids a run of five equal bits
      alt7 = (y == 3'h7) && ((!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
                             (rd6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
      c4   = alt7 ? 4'h7 : TAB4[y];
      next_rd = ($countones(c4) == 2) ? rd6 : ~rd6;
      if (rd6 && (($countones(c4) != 2) || (y == 3'h3))) begin
         c4 = ~c4;
      end
      next_code = {c6, c4};
      if (sym.k) begin
         next_code = rd ? `ASF_K28_5_POS : `ASF_K28_5_NEG;
         next_rd   = ~rd;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         code <= `ASF_K28_5_NEG;
         rd   <= 1'b0;
      end else if (load) begin
         code <= next_code;
         rd   <= next_rd;
      end
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   disparity_track_a: assert property (@(posedge mclk) disable iff (!rst_n)
      load |=> ($countones(code) inside {4, 5, 6}) &&
               (($countones(code) == 4) == $past(rd) || $countones(code) == 5))
      else $error("code group breaks running disparity");

endmodule // asf_lane_enc

// ==== verification/asf_rx_model.sv ====
// Receiver-side model: serializer back-pressure and sync request pin
`timescale 1ns/1ns
module asf_rx_model (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // Test controls
   input  wire logic slow,
   input  wire logic stall,
   input  wire logic sync_req,
   // Link side
   output logic      lane_ready,
   output logic      sync_n
);
   // ------------------------------------------------------------------------
   // Behaviour
   // ------------------------------------------------------------------------
   // Slow mode takes every other cycle, so output words must wait
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) lane_ready <= 1'b0;
      else lane_ready <= !stall && (!slow || !lane_ready);
   end
   // Held low for as long as realignment is wanted
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) sync_n <= 1'b1;
      else sync_n <= !sync_req;
   end
endmodule // asf_rx_model

// ==== verification/asf_framer_tb.sv ====
// Self-checking bench of the serial lane framer
`timescale 1ns/1ns
`include "asf_cfg.svh"
module asf_framer_tb;
   // ------------------------------------------------------------------------
   // Signals and tables
   // ------------------------------------------------------------------------
   logic        mclk = 1'b0, rst_n = 1'b0, sample_valid = 1'b0, sync_req = 1'b0;
   logic        dual_lane = 1'b0, pd_full = 1'b0, pd_fast = 1'b0, pd_soft = 1'b0;
   logic        clk_restart = 1'b0, slow = 1'b0, stall = 1'b0;
   logic [13:0] sample_in = 14'h0000;
   logic        sample_ready, lane_k, lane_ready, sync_n, ok;
   logic [9:0]  lane0_code, lane1_code;
   logic [1:0]  lane_valid;
   logic [7:0]  q0[$], q1[$];
   logic        rd[2];
   int          fails = 0, cmp_count = 0, n, on, acc;
   localparam logic [29:0] rows [7] = '{{14'h3FFF, 8'hFF, 8'hFC}, {14'h0000, 8'h00, 8'h00},
      {14'h2AAA, 8'hAA, 8'hA8}, {14'h1555, 8'h55, 8'h54}, {14'h0001, 8'h00, 8'h04},
      {14'h2000, 8'h80, 8'h00}, {14'h3C7B, 8'hF1, 8'hEC}};
   localparam logic [5:0] code6_tab [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29,
      6'h19, 6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23,
      6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E,
      6'h1E, 6'h2B};
   localparam logic [3:0] code4_tab [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
   localparam int wake_cyc [4] = '{`ASF_WAKE_FULL_CYC, `ASF_WAKE_FULL_CYC,
      `ASF_WAKE_SOFT_CYC, `ASF_WAKE_CLK_CYC};

   always #25 mclk = ~mclk;

   asf_framer dut_u (.mclk(mclk), .rst_n(rst_n), .sample_in(sample_in),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .sync_n(sync_n),
      .dual_lane(dual_lane), .pd_full(pd_full), .pd_fast(pd_fast), .pd_soft(pd_soft),
      .clk_restart(clk_restart), .lane0_code(lane0_code), .lane1_code(lane1_code),
      .lane_valid(lane_valid), .lane_k(lane_k), .lane_ready(lane_ready));
   asf_rx_model rx_u (.mclk(mclk), .rst_n(rst_n), .slow(slow), .stall(stall),
      .sync_req(sync_req), .lane_ready(lane_ready), .sync_n(sync_n));

   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------
   task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Reference coder, kept apart from the design's tables on purpose
   function automatic logic [9:0] enc8(input logic [7:0] d, inout logic r);
      logic [5:0] s;
      logic [3:0] f;
      s = code6_tab[d[4:0]];
      if (r && ($countones(s) != 3 || d[4:0] == 5'h07)) s = ~s;
      if ($countones(s) != 3) r = ~r;
      f = code4_tab[d[7:5]];
      if (d[7:5] == 3'h7 && (r ? d[4:0] inside {5'h0B, 5'h0D, 5'h0E}
                               : d[4:0] inside {5'h11, 5'h12, 5'h14})) f = 4'h7;
      if (r && ($countones(f) != 2 || d[7:5] == 3'h3)) f = ~f;
      if ($countones(f) != 2) r = ~r;
      return {s, f};
   endfunction

   task automatic take_lane(input int ln, input logic [9:0] code);
      logic [7:0] b;
      logic       r;
      r = rd[ln];
      if (lane_k === 1'b1) begin
         check(code, r ? `ASF_K28_5_POS : `ASF_K28_5_NEG, "sync symbol");
         rd[ln] = ~r;
      end else if ((ln == 1 ? q1.size() : q0.size()) == 0) begin
         check(1'b0, 1'b1, "word not expected");
      end else begin
         b = (ln == 1) ? q1.pop_front() : q0.pop_front();
         check(code, enc8(b, r), "data code");
         rd[ln] = r;
      end
   endtask

   // Every take on the lanes is judged here
   always @(posedge mclk) begin
      if (rst_n === 1'b1 && lane_valid !== 2'b00 && lane_ready === 1'b1) begin
         check(lane_valid, dual_lane ? 2'b11 : 2'b01, "lane pattern");
         take_lane(0, lane0_code);
         if (dual_lane) take_lane(1, lane1_code);
      end
   end

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      check(sample_ready, 1'b1, "ready in reset");
      check(lane_valid, 2'b00, "lanes in reset");
      check(lane_k, 1'b0, "sync flag in reset");
      check(lane0_code, `ASF_K28_5_NEG, "lane 0 code in reset");
      check(lane1_code, `ASF_K28_5_NEG, "lane 1 code in reset");
      rd = '{1'b0, 1'b0};
      q0.delete();
      q1.delete();
      rst_n = 1'b1;
      repeat (5) @(posedge mclk);
      #1;
   endtask

   task automatic send(input logic [13:0] s, input logic [7:0] hi, input logic [7:0] lo);
      int k;
      logic took;
      sample_in = s;
      sample_valid = 1'b1;
      k = 0;
      do begin
         took = sample_ready === 1'b1;
         @(posedge mclk);
         #1;
         k++;
      end while (!took && k < 60);
      check(took, 1'b1, "sample refused");
      q0.push_back(hi);
      if (dual_lane) q1.push_back(lo);
      else q0.push_back(lo);
   endtask

   task automatic drain();
      int k;
      sample_valid = 1'b0;
      for (k = 0; k < 200 && (q0.size() + q1.size() != 0 || lane_valid !== 2'b00); k++) begin
         @(posedge mclk);
         #1;
      end
      check(10'(q0.size() + q1.size()), 10'h000, "words lost");
      check(lane_valid, 2'b00, "lanes idle");
   endtask

   // ------------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      $display("CHECK FAILED at %0t: watchdog ran out", $time);
      stop_test();
   end

   initial begin
      do_reset();
      $display("Test reset done");
      for (int dl = 0; dl < 2; dl++) begin
         dual_lane = dl[0];
         slow = dl[0];
         repeat (5) @(posedge mclk);
         #1;
         foreach (rows[i]) send(rows[i][29:16], rows[i][15:8], rows[i][7:0]);
         drain();
      end
      $display("Test rows done");
      // Stalled receiver in dual mode: buffer must fill, then refuse
      stall = 1'b1;
      acc = 0;
      sample_in = 14'h2AAA;
      sample_valid = 1'b1;
      repeat (10) begin
         ok = sample_ready === 1'b1;
         @(posedge mclk);
         #1;
         if (ok) begin
            acc++;
            q0.push_back(8'hAA);
            q1.push_back(8'hA8);
         end
      end
      check(sample_ready, 1'b0, "buffer full");
      check(acc >= 2 && acc <= 4, 1'b1, "buffer depth");
      stall = 1'b0;
      drain();
      $display("Test back-pressure done");
      for (int dl = 0; dl < 2; dl++) begin
         dual_lane = dl[0];
         slow = 1'b0;
         repeat (5) @(posedge mclk);
         #1;
         send(14'h1555, 8'h55, 8'h54);
         send(14'h3FFF, 8'hFF, 8'hFC);
         sample_valid = 1'b0;
         sync_req = 1'b1;
         for (n = 0; n < 40 && lane_k !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
         end
         q0.delete();
         q1.delete();
         on = n;
         // Five extra edges: partner flop, three pin stages, capture stage
         check(10'(on), 10'(`ASF_SYNC_ON_LAT + 5), "sync start latency");
         repeat (20) @(posedge mclk);
         #1;
         check(lane_k, 1'b1, "sync still held");
         sync_req = 1'b0;
         for (n = 0; n < 40 && lane_k !== 1'b0; n++) begin
            @(posedge mclk);
            #1;
         end
         check(10'(n), 10'(`ASF_SYNC_OFF_LAT + 5), "sync end latency");
         send(14'h2000, 8'h80, 8'h00);
         drain();
      end
      $display("Test sync done");
      dual_lane = 1'b0;
      for (int m = 0; m < 4; m++) begin
         do_reset();
         if (m < 3) begin
            {pd_full, pd_fast, pd_soft} = 3'b100 >> m;
            repeat (10) @(posedge mclk);
            #1;
            {pd_full, pd_fast, pd_soft} = 3'b000;
         end else clk_restart = 1'b1;
         q0.push_back(8'hFF);
         q0.push_back(8'hFC);
         sample_in = 14'h3FFF;
         sample_valid = 1'b1;
         for (n = 0; n < 1100 && lane_valid === 2'b00; n++) begin
            ok = sample_ready === 1'b1;
            @(posedge mclk);
            #1;
            clk_restart = 1'b0;
            if (ok) sample_valid = 1'b0;
         end
         check(n >= wake_cyc[m] && n <= wake_cyc[m] + 8, 1'b1, "wake time");
         drain();
      end
      $display("Test wake done");
      stop_test();
   end
endmodule // asf_framer_tb
